//--- bench/per_event_src_model.sv
/*
 * Far-side model: the system event pins that feed the event router.
 * Assumes the bench calls drive() from one process only, never twice in one time step.
 */
`timescale 1ns/100ps
module per_event_src_model (
    input wire logic clk_in,
    output logic [7:0] gev_out,
    output logic [7:0] mon_a_out,
    output logic [7:0] mon_b_out,
    output logic [3:0] misc_out
);
    // ==================================================================
    // Pin driving.
    // All pins start low so that reset sees a quiet system.
    initial begin
        {misc_out, mon_b_out, mon_a_out, gev_out} = 28'h0000000;
    end

    // Changes the pins just after an edge and holds them eight cycles,
    // well past the two-cycle minimum that the synchronisers need.
    task automatic drive(input logic [27:0] pins);
        @(posedge clk_in);
        {misc_out, mon_b_out, mon_a_out, gev_out} <= pins;
        repeat (8) @(posedge clk_in);
    endtask
endmodule // per_event_src_model

//--- bench/per_pm_event_router_props.sv
/*
 * Event router checker: APB timing and interrupt pins.
 * Assumes binding to the router; sees its ports only.
 */
`timescale 1ns/100ps
module per_pm_event_router_props #(
    parameter int NUM_GEV = 8,
    parameter int APB_ADDR_W = 12
) (
    input logic core_clk_in,
    input logic rst_n_in,
    input logic psel_in,
    input logic penable_in,
    input logic pwrite_in,
    input logic [APB_ADDR_W-1:0] paddr_in,
    input logic [31:0] prdata_out,
    input logic pready_out,
    input logic pslverr_out,
    input logic [NUM_GEV-1:0] general_event_in,
    input logic [7:0] monitor_group_a_in,
    input logic [7:0] monitor_group_b_in,
    input logic thermal_alert_in,
    input logic control_irq_out,
    input logic mgmt_irq_n_out,
    input logic irq13_out,
    input logic irq_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // ==================================================================
    // Quiet counter: cycles since the last pin change or register write.
    logic [NUM_GEV+16:0] ev_prev_reg; // Last sampled pins.
    logic [2:0] quiet_reg; // Saturates at 7, past the event latency.
    wire [NUM_GEV+16:0] ev_now = {general_event_in, monitor_group_a_in, monitor_group_b_in,
        thermal_alert_in};
    // Restarts on reset, a write, or a change on the general, monitor or thermal pins, not legacy, USB or AC97.
    always_ff @(posedge core_clk_in) begin
        ev_prev_reg <= ev_now;
        if (!rst_n_in || ev_now != ev_prev_reg || (psel_in && penable_in && pwrite_in)) begin
            quiet_reg <= 3'h0;
        end else if (quiet_reg != 3'h7) begin
            quiet_reg <= quiet_reg + 3'h1;
        end
    end
    // ==================================================================
    // Assertions.
    sequence setup_s;
        psel_in && !penable_in;
    endsequence
    sequence access_s;
        psel_in && penable_in && pready_out;
    endsequence
    AST_READY_ACCESS: assert property (pready_out == (psel_in && penable_in))
        else $error("pready outside access or missing");
    AST_HANDSHAKE: assert property (setup_s |=> access_s)
        else $error("access phase not answered at once");
    AST_ERR_IN_ACCESS: assert property (pslverr_out |-> psel_in && penable_in)
        else $error("pslverr outside access");
    AST_ERR_READ_ZERO: assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
        else $error("refused read returns data");
    AST_MAPPED_OK: assert property (psel_in && penable_in && paddr_in[9:2] inside {[8'h30:8'h3C]}
        |-> !pslverr_out)
        else $error("mapped register refused");
    AST_PRDATA_HOLD: assert property (!(psel_in && !penable_in && !pwrite_in) |=> $stable(prdata_out))
        else $error("read data moved without read");
    AST_RESET_IDLE: assert property ($rose(rst_n_in) |-> mgmt_irq_n_out && !control_irq_out
        && !irq13_out && !irq_out)
        else $error("interrupt pins not idle after reset");
    AST_QUIET_STABLE: assert property (quiet_reg == 3'h7 |->
        $stable({control_irq_out, mgmt_irq_n_out, irq13_out, irq_out}))
        else $error("interrupt pin moved without cause");
endmodule // per_pm_event_router_props
bind per_pm_event_router per_pm_event_router_props #(.NUM_GEV(NUM_GEV), .APB_ADDR_W(APB_ADDR_W))
    u_per_pm_event_router_props (.*);

//--- bench/per_pm_event_router_tb_top.sv
/*
 * Event router bench: APB register tests and routed events.
 * Assumes the pin model and bound checker are compiled with it.
 */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module per_pm_event_router_tb_top;
    logic core_clk_in, rst_n_in, psel, penable, pwrite, pready, pslverr, err;
    logic sci, smi_n, irq13, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [27:0] ev; // Pin set handed to the model.
    wire [7:0] gev, mon_a, mon_b;
    wire [3:0] misc;
    int bad_count, tests_run, i;
    // Route codes, ACPI path selects and expected {sci, smi_n, irq13, irq} per step.
    logic [9:0] codes = 10'h390;
    logic [4:0] sels = 5'h01;
    logic [19:0] exps = 20'h7111D;
    per_event_src_model u_per_event_src_model (.clk_in(core_clk_in), .gev_out(gev),
        .mon_a_out(mon_a), .mon_b_out(mon_b), .misc_out(misc));
    per_pm_event_router u_per_pm_event_router (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .general_event_in(gev), .monitor_group_a_in(mon_a), .monitor_group_b_in(mon_b),
        .legacy_smi_event_in(misc[0]), .thermal_alert_in(misc[1]), .usb_wake_event_in(misc[2]),
        .ac97_wake_event_in(misc[3]), .control_irq_out(sci), .mgmt_irq_n_out(smi_n),
        .irq13_out(irq13), .irq_out(irq));
    // ==================================================================
    // Tasks.
    // One APB transfer; the request stands until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n;
        @(posedge core_clk_in);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, 2'h0, idx, 2'h0, d};
        @(posedge core_clk_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) bad_count++;
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask
    // Sets one pin; the model holds it eight cycles.
    task automatic pin(input int b, input logic v);
        ev[b] = v;
        u_per_event_src_model.drive(ev);
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [31:0] e);
        apb(1'b0, idx, 32'h0);
        `CHK("read", e, rd)
    endtask
    // Pins are looked at two edges on, where a clear has settled.
    task automatic pchk(input logic [3:0] e);
        repeat (2) @(posedge core_clk_in);
        #1 `CHK("pins", e, {sci, smi_n, irq13, irq})
    endtask
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ==================================================================
    // Clock, watchdog and the main sequence.
    initial begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end
    // The tests take about 500 cycles; 20000 leaves ample margin.
    initial begin
        #400000;
        bad_count++;
        stop_test();
    end
    initial begin
        {rst_n_in, psel, penable, pwrite, paddr, pwdata, ev} = '0;
        repeat (20) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        for (i = 0; i < 13; i++) rchk(8'h30 + i, 32'h0);
        pchk(4'h4);
        apb(1'b0, 8'h40, 32'h0);
        `CHK("err", 1'b1, err)
        `CHK("err_data", 32'h0, rd)
        // Read-write registers echo a pattern; flag registers are skipped.
        for (i = 0; i < 13; i++) if (i < 9 || i > 11) begin
            wr(8'h30 + i, 32'hC3 ^ i);
            rchk(8'h30 + i, 32'hC3 ^ i);
            wr(8'h30 + i, 32'h0);
        end
        wr(8'h61, 32'h1);
        wr(8'h36, 32'h1);
        // Every route code on general event zero, rising edge selected.
        for (i = 0; i < 5; i++) begin
            wr(8'h62, sels[i]);
            wr(8'h30, codes[2*i +: 2]);
            pin(0, 1'b1);
            rchk(8'h39, 32'h1);
            pchk(exps[4*i +: 4]);
            if (codes[2*i +: 2] == 2'h2) begin
                rchk(8'h5A, 32'h1);
                wr(8'h5A, 32'h1);
                pchk(4'hD);
            end
            wr(8'h39, 32'h1);
            wr(8'h60, 32'h1);
            rchk(8'h39, 32'h0);
            pchk(4'h4);
            pin(0, 1'b0);
            rchk(8'h39, 32'h0);
        end
        // Masked summary interrupt stays low while its status is still recorded.
        wr(8'h61, 32'h0);
        pin(0, 1'b1);
        rchk(8'h60, 32'h1);
        pchk(4'h6);
        wr(8'h36, 32'h0);
        wr(8'h39, 32'h3);
        pin(1, 1'b1);
        rchk(8'h39, 32'h0);
        pin(1, 1'b0);
        rchk(8'h39, 32'h2);
        wr(8'h39, 32'h2);
        // External event one to SMI, storage event to IRQ13, thermal alert to IRQ13.
        wr(8'h30, 32'h0);
        wr(8'h37, 32'h2);
        wr(8'h32, 32'h4);
        pin(9, 1'b1);
        rchk(8'h3A, 32'h2);
        pchk(4'h0);
        wr(8'h3A, 32'h2);
        pchk(4'h4);
        wr(8'h38, 32'h80);
        wr(8'h35, 32'hC0);
        pin(23, 1'b1);
        rchk(8'h3B, 32'h80);
        pchk(4'h6);
        wr(8'h3B, 32'h80);
        wr(8'h3C, 32'h0C);
        pin(25, 1'b1);
        rchk(8'h63, 32'h2);
        pchk(4'h6);
        wr(8'h63, 32'hF);
        pchk(4'h4);
        stop_test();
    end
endmodule // per_pm_event_router_tb_top

//--- verilog/per_params.svh
/*
 * Event router constants: register indices, reset values, bus shape.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef PER_PARAMS_SVH
`define PER_PARAMS_SVH

// ==================================================================
// Register indices in the power index space (byte address = index * 4).
`define PER_IDX_GEV_ROUTE_LO 8'h30
`define PER_IDX_GEV_ROUTE_HI 8'h31
`define PER_IDX_MON_ROUTE_A 8'h32
`define PER_IDX_MON_ROUTE_B 8'h33
`define PER_IDX_MON_ROUTE_C 8'h34
`define PER_IDX_MON_ROUTE_D 8'h35
`define PER_IDX_GEV_EDGE 8'h36
`define PER_IDX_MON_EDGE_A 8'h37
`define PER_IDX_MON_EDGE_B 8'h38
`define PER_IDX_GEV_FLAGS 8'h39
`define PER_IDX_WAKE_FLAGS_A 8'h3A
`define PER_IDX_WAKE_FLAGS_B 8'h3B
`define PER_IDX_MISC_ROUTE 8'h3C
`define PER_IDX_GEV_SMISCI 8'h5A
`define PER_IDX_IRQ_STATUS 8'h60
`define PER_IDX_IRQ_MASK 8'h61
`define PER_IDX_CONTROL 8'h62
`define PER_IDX_MISC_FLAGS 8'h63
`define PER_IDX_OTHER_SMISCI 8'h64

// ==================================================================
// Reset values.
`define PER_RST_BYTE 8'h00
`define PER_RST_MISC 4'h0
`define PER_RST_OTHER 20'h00000
`define PER_RST_IRQ 3'h0
`define PER_RST_WORD 32'h00000000

// ==================================================================
// Bus shape: word index sits above the two byte-offset bits.
`define PER_IDX_LSB 2
`define PER_IDX_W 8

`endif

//--- verilog/per_pkg.sv
/*
 * Types shared by the power-management event router.
 * Assumes nothing of its surroundings; it holds declarations only.
 */
package per_pkg;

    // ==================================================================
    // Two-bit routing code carried by every event source.
    typedef enum logic [1:0] {
        PER_ROUTE_ACPI = 2'h0,
        PER_ROUTE_SMI = 2'h1,
        PER_ROUTE_SMI_SCI = 2'h2,
        PER_ROUTE_IRQ13 = 2'h3
    } per_route_t;

    // Processor-facing interrupt requests, carried together.
    typedef struct packed {
        logic sci;
        logic smi;
        logic irq13;
    } per_irq_t;

endpackage

//--- verilog/per_pm_event_router.sv
/*
 * Power-management event router: synchronised edge detection on 28 sources,
 * sticky flags and routing to SCI, SMI or IRQ13, under APB control.
 * Assumes one 50 MHz clock, synchronous active-low reset, an APB3 master.
 */
// Design decision made here: register access over APB.
// Functional notes
// - Route 00 gives SCI or SMI per select.
// - 01 SMI, 10 SMI then SCI, 11 IRQ13.
// - Index 32h routes ext1, PCIe, monitor0.
// - Index 33h routes monitors 1, 2, 3, 8.
// - Index 34h routes wake0, monitors 4, 5, audio.
// - Index 35h routes monitors 6, 7, wake2, storage.
// - Index 3Ch routes legacy, thermal, USB, AC97.
// - Routing fields reset to 00.
// - Index 36h: general event edge polarity.
// - Index 37h: first monitor group polarity.
// - Index 38h: second monitor group polarity.
// - Index 39h: general event flags, W1C.
// - Index 3Ah: first group flags, W1C.
// - Index 3Bh: second group flags, W1C.
// - Indices 30h, 31h route general events.
// - Separate SMI-then-SCI flags for general events.

`timescale 1ns/100ps
`include "per_params.svh"

module per_pm_event_router #(
    parameter int NUM_GEV = 8,
    parameter int APB_ADDR_W = 12
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // APB3 slave.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [APB_ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Event sources.
    input wire logic [NUM_GEV-1:0] general_event_in,
    input wire logic [7:0] monitor_group_a_in,
    input wire logic [7:0] monitor_group_b_in,
    input wire logic legacy_smi_event_in,
    input wire logic thermal_alert_in,
    input wire logic usb_wake_event_in,
    input wire logic ac97_wake_event_in,
    // Processor interrupt outputs.
    output logic control_irq_out,
    output logic mgmt_irq_n_out,
    output logic irq13_out,
    output logic irq_out
);

    // ==================================================================
    // Elaboration checks.
    localparam int NUM_SRC = 28;
    initial begin
        if (NUM_GEV != 8) begin
            $error("NUM_GEV must be 8.");
        end
        if (APB_ADDR_W < `PER_IDX_W + `PER_IDX_LSB) begin
            $error("APB_ADDR_W too narrow.");
        end
    end

    // ==================================================================
    // Source vector: [7:0] general events, [15:8] first monitor group,
    // [23:16] second monitor group, [27:24] misc sources.
    logic [NUM_SRC-1:0] src_raw; // Unsynchronised source levels.
    assign src_raw = {ac97_wake_event_in, usb_wake_event_in, thermal_alert_in,
                      legacy_smi_event_in, monitor_group_b_in, monitor_group_a_in,
                      general_event_in};

    // ==================================================================
    // Register state.
    logic [7:0] gev_route_lo_reg; // Events 0-3 routes.
    logic [7:0] gev_route_hi_reg; // Events 4-7 routes.
    logic [7:0] monitor_route_a_reg; // First monitor routes.
    logic [7:0] monitor_route_b_reg; // Monitors 1-3, 8.
    logic [7:0] monitor_route_c_reg; // Wake zero, monitors 4-5, audio.
    logic [7:0] monitor_route_d_reg; // Monitors 6-7, wake two, storage.
    logic [7:0] misc_source_route_reg; // Legacy, thermal, USB, AC97.

    logic [7:0] general_event_edge_select_reg; // General event polarity.
    logic [7:0] monitor_edge_select_a_reg; // First group polarity.
    logic [7:0] monitor_edge_select_b_reg; // Second group polarity.

    logic [NUM_SRC-1:0] flags_reg; // Sticky event flags.
    logic [NUM_SRC-1:0] smisci_reg; // Pending SMI half of SMI-then-SCI.
    logic [2:0] irq_status_reg; // Sticky group events.
    logic [2:0] irq_mask_reg; // Enables for irq_status_reg.

    logic acpi_path_select_reg; // 1: ACPI events raise SCI, 0: SMI.
    logic [31:0] prdata_reg; // Read data captured in setup.

    // ==================================================================
    // Bus decode. Reads are captured in setup, writes act in access.
    logic [`PER_IDX_W-1:0] idx; // Word index of the current transfer.
    logic setup_ph; // Setup cycle.
    logic access_ph; // Access cycle; completes at once.
    logic wr_en; // Write takes effect at this edge.
    logic idx_hit; // Index maps onto a register.
    assign idx = paddr_in[`PER_IDX_LSB +: `PER_IDX_W];
    assign setup_ph = psel_in & ~penable_in;
    assign access_ph = psel_in & penable_in;
    assign wr_en = access_ph & pwrite_in & idx_hit;
    assign pready_out = access_ph;
    assign pslverr_out = access_ph & ~idx_hit;

    // Per-register write strobes.
    logic wr_gev_lo;
    logic wr_gev_hi;
    logic wr_mon_a;
    logic wr_mon_b;
    logic wr_mon_c;
    logic wr_mon_d;
    logic wr_misc_route;

    logic wr_gev_edge;
    logic wr_edge_a;
    logic wr_edge_b;
    logic wr_gev_flags;
    logic wr_flags_a;
    logic wr_flags_b;

    logic wr_gev_smisci;
    logic wr_irq_status;
    logic wr_irq_mask;
    logic wr_control;
    logic wr_misc_flags;
    logic wr_other_smisci;
    assign wr_gev_lo = wr_en & (idx == `PER_IDX_GEV_ROUTE_LO);
    assign wr_gev_hi = wr_en & (idx == `PER_IDX_GEV_ROUTE_HI);
    assign wr_mon_a = wr_en & (idx == `PER_IDX_MON_ROUTE_A);
    assign wr_mon_b = wr_en & (idx == `PER_IDX_MON_ROUTE_B);
    assign wr_mon_c = wr_en & (idx == `PER_IDX_MON_ROUTE_C);
    assign wr_mon_d = wr_en & (idx == `PER_IDX_MON_ROUTE_D);
    assign wr_misc_route = wr_en & (idx == `PER_IDX_MISC_ROUTE);
    assign wr_gev_edge = wr_en & (idx == `PER_IDX_GEV_EDGE);
    assign wr_edge_a = wr_en & (idx == `PER_IDX_MON_EDGE_A);
    assign wr_edge_b = wr_en & (idx == `PER_IDX_MON_EDGE_B);
    assign wr_gev_flags = wr_en & (idx == `PER_IDX_GEV_FLAGS);
    assign wr_flags_a = wr_en & (idx == `PER_IDX_WAKE_FLAGS_A);
    assign wr_flags_b = wr_en & (idx == `PER_IDX_WAKE_FLAGS_B);
    assign wr_gev_smisci = wr_en & (idx == `PER_IDX_GEV_SMISCI);
    assign wr_irq_status = wr_en & (idx == `PER_IDX_IRQ_STATUS);
    assign wr_irq_mask = wr_en & (idx == `PER_IDX_IRQ_MASK);
    assign wr_control = wr_en & (idx == `PER_IDX_CONTROL);
    assign wr_misc_flags = wr_en & (idx == `PER_IDX_MISC_FLAGS);
    assign wr_other_smisci = wr_en & (idx == `PER_IDX_OTHER_SMISCI);

    // Read multiplexer; narrow registers sit in the low bits, the rest read zero.
    logic [31:0] rd_mux;
    always_comb begin
        idx_hit = 1'b1;
        rd_mux = `PER_RST_WORD;
        if (idx == `PER_IDX_GEV_ROUTE_LO) begin
            rd_mux[7:0] = gev_route_lo_reg;
        end else if (idx == `PER_IDX_GEV_ROUTE_HI) begin
            rd_mux[7:0] = gev_route_hi_reg;
        end else if (idx == `PER_IDX_MON_ROUTE_A) begin
            rd_mux[7:0] = monitor_route_a_reg;
        end else if (idx == `PER_IDX_MON_ROUTE_B) begin
            rd_mux[7:0] = monitor_route_b_reg;
        end else if (idx == `PER_IDX_MON_ROUTE_C) begin
            rd_mux[7:0] = monitor_route_c_reg;
        end else if (idx == `PER_IDX_MON_ROUTE_D) begin
            rd_mux[7:0] = monitor_route_d_reg;
        end else if (idx == `PER_IDX_MISC_ROUTE) begin
            rd_mux[7:0] = misc_source_route_reg;
        end else if (idx == `PER_IDX_GEV_EDGE) begin
            rd_mux[7:0] = general_event_edge_select_reg;
        end else if (idx == `PER_IDX_MON_EDGE_A) begin
            rd_mux[7:0] = monitor_edge_select_a_reg;
        end else if (idx == `PER_IDX_MON_EDGE_B) begin
            rd_mux[7:0] = monitor_edge_select_b_reg;
        end else if (idx == `PER_IDX_GEV_FLAGS) begin
            rd_mux[7:0] = flags_reg[7:0];
        end else if (idx == `PER_IDX_WAKE_FLAGS_A) begin
            rd_mux[7:0] = flags_reg[15:8];
        end else if (idx == `PER_IDX_WAKE_FLAGS_B) begin
            rd_mux[7:0] = flags_reg[23:16];
        end else if (idx == `PER_IDX_GEV_SMISCI) begin
            rd_mux[7:0] = smisci_reg[7:0];
        end else if (idx == `PER_IDX_IRQ_STATUS) begin
            rd_mux[2:0] = irq_status_reg;
        end else if (idx == `PER_IDX_IRQ_MASK) begin
            rd_mux[2:0] = irq_mask_reg;
        end else if (idx == `PER_IDX_CONTROL) begin
            rd_mux[0] = acpi_path_select_reg;
        end else if (idx == `PER_IDX_MISC_FLAGS) begin
            rd_mux[3:0] = flags_reg[27:24];
        end else if (idx == `PER_IDX_OTHER_SMISCI) begin
            rd_mux[19:0] = smisci_reg[27:8];
        end else begin
            // Unmapped index: zero data and an error response.
            idx_hit = 1'b0;
        end
    end

    // Read data is captured in setup so prdata_out comes straight from a flop.
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            prdata_reg <= `PER_RST_WORD;
        end else if (setup_ph && !pwrite_in) begin
            prdata_reg <= rd_mux;
        end
    end
    assign prdata_out = prdata_reg;

    // ==================================================================
    // Configuration registers. All routing fields start at ACPI.
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            gev_route_lo_reg <= `PER_RST_BYTE;
            gev_route_hi_reg <= `PER_RST_BYTE;
            monitor_route_a_reg <= `PER_RST_BYTE;
            monitor_route_b_reg <= `PER_RST_BYTE;
            monitor_route_c_reg <= `PER_RST_BYTE;
            monitor_route_d_reg <= `PER_RST_BYTE;
            misc_source_route_reg <= `PER_RST_BYTE;
        end else begin
            if (wr_gev_lo) gev_route_lo_reg <= pwdata_in[7:0];
            if (wr_gev_hi) gev_route_hi_reg <= pwdata_in[7:0];
            if (wr_mon_a) monitor_route_a_reg <= pwdata_in[7:0];
            if (wr_mon_b) monitor_route_b_reg <= pwdata_in[7:0];
            if (wr_mon_c) monitor_route_c_reg <= pwdata_in[7:0];
            if (wr_mon_d) monitor_route_d_reg <= pwdata_in[7:0];
            if (wr_misc_route) misc_source_route_reg <= pwdata_in[7:0];
        end
    end

    // Edge polarity, interrupt mask and the ACPI path select.
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            general_event_edge_select_reg <= `PER_RST_BYTE;
            monitor_edge_select_a_reg <= `PER_RST_BYTE;
            monitor_edge_select_b_reg <= `PER_RST_BYTE;
            irq_mask_reg <= `PER_RST_IRQ;
            acpi_path_select_reg <= 1'b0;
        end else begin
            if (wr_gev_edge) general_event_edge_select_reg <= pwdata_in[7:0];
            if (wr_edge_a) monitor_edge_select_a_reg <= pwdata_in[7:0];
            if (wr_edge_b) monitor_edge_select_b_reg <= pwdata_in[7:0];
            if (wr_irq_mask) irq_mask_reg <= pwdata_in[2:0];
            if (wr_control) acpi_path_select_reg <= pwdata_in[0];
        end
    end

    // ==================================================================
    // Synchronisers: stage one feeds only stage two; stage three is the older sample.
    logic [NUM_SRC-1:0] sync1_reg; // First synchroniser stage.
    logic [NUM_SRC-1:0] sync2_reg; // Second stage, safe to use.
    logic [NUM_SRC-1:0] prev_reg; // Sample one cycle older than sync2_reg.
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg <= '0;
        end else begin
            sync1_reg <= src_raw;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // Packed views of routing and polarity, indexed by source number.
    // Misc sources have no polarity bits; they trigger on the rising edge.
    logic [2*NUM_SRC-1:0] route_vec; // Source i at [2i+1:2i].
    logic [NUM_SRC-1:0] edge_sel; // 1: rising, 0: falling.
    assign route_vec = {misc_source_route_reg, monitor_route_d_reg, monitor_route_c_reg,
                        monitor_route_b_reg, monitor_route_a_reg, gev_route_hi_reg,
                        gev_route_lo_reg};
    assign edge_sel = {4'hF, monitor_edge_select_b_reg, monitor_edge_select_a_reg,
                       general_event_edge_select_reg};

    logic [NUM_SRC-1:0] edge_hit; // One-cycle pulse on the selected edge.
    logic [NUM_SRC-1:0] smisci_set; // Edge on a source routed SMI-then-SCI.
    logic [NUM_SRC-1:0] sci_req; // Per-source control interrupt request.
    logic [NUM_SRC-1:0] smi_req; // Per-source management interrupt request.
    logic [NUM_SRC-1:0] irq13_req; // Per-source IRQ13 request.

    // Per-source edge test and route decode.
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        per_pkg::per_route_t route; // This source's routing code.
        assign route = per_pkg::per_route_t'(route_vec[2*i +: 2]);
        // Compare consecutive synchronised samples: one transition, one pulse.
        assign edge_hit[i] = edge_sel[i] ? (sync2_reg[i] & ~prev_reg[i])
                                         : (~sync2_reg[i] & prev_reg[i]);
        assign smisci_set[i] = edge_hit[i] & (route == per_pkg::PER_ROUTE_SMI_SCI);
        // ACPI follows the global select; SMI-then-SCI gives SCI once SMI half is done.
        assign sci_req[i] = flags_reg[i] & (((route == per_pkg::PER_ROUTE_ACPI)
                            & acpi_path_select_reg) | ((route == per_pkg::PER_ROUTE_SMI_SCI)
                            & ~smisci_reg[i]));
        assign smi_req[i] = (flags_reg[i] & (((route == per_pkg::PER_ROUTE_ACPI)
                            & ~acpi_path_select_reg) | (route == per_pkg::PER_ROUTE_SMI)))
                            | smisci_reg[i];
        assign irq13_req[i] = flags_reg[i] & (route == per_pkg::PER_ROUTE_IRQ13);
    end

    // ==================================================================
    // Sticky flags. Write-one-clear, and a set in the same cycle wins.
    logic [NUM_SRC-1:0] flag_clr; // Bits software clears this cycle.
    logic [NUM_SRC-1:0] smisci_clr; // SMI-then-SCI bits cleared this cycle.
    logic [NUM_SRC-1:0] flags_next;
    logic [NUM_SRC-1:0] smisci_next;
    assign flag_clr = {wr_misc_flags ? pwdata_in[3:0] : 4'h0,
                       wr_flags_b ? pwdata_in[7:0] : 8'h00,
                       wr_flags_a ? pwdata_in[7:0] : 8'h00,
                       wr_gev_flags ? pwdata_in[7:0] : 8'h00};
    assign smisci_clr = {wr_other_smisci ? pwdata_in[19:0] : 20'h00000,
                         wr_gev_smisci ? pwdata_in[7:0] : 8'h00};
    assign flags_next = (flags_reg & ~flag_clr) | edge_hit;
    assign smisci_next = (smisci_reg & ~smisci_clr) | smisci_set;

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            flags_reg <= '0;
            smisci_reg <= '0;
        end else begin
            flags_reg <= flags_next;
            smisci_reg <= smisci_next;
        end
    end

    // ==================================================================
    // Interrupt status: bit 0 general event edge, bit 1 monitor edge,
    // bit 2 misc edge. Set wins over a write-one clear in the same cycle.
    logic [2:0] irq_set; // Group event pulses.
    logic [2:0] irq_status_next;
    assign irq_set = {|edge_hit[27:24], |edge_hit[23:8], |edge_hit[7:0]};
    assign irq_status_next = (irq_status_reg &
                              ~(wr_irq_status ? pwdata_in[2:0] : 3'h0)) | irq_set;

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            irq_status_reg <= `PER_RST_IRQ;
        end else begin
            irq_status_reg <= irq_status_next;
        end
    end

    // ==================================================================
    // Output stage. Registered so the pins never glitch on decode changes;
    // the cost is one cycle from flag to pin, except irq_out, which is registered from irq_status_next.
    per_pkg::per_irq_t irq_next; // Combined requests.
    per_pkg::per_irq_t irq_reg; // Registered requests.
    logic irq_line_reg; // Registered summary interrupt.
    assign irq_next.sci = |sci_req;
    assign irq_next.smi = |smi_req;
    assign irq_next.irq13 = |irq13_req;

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            irq_reg <= '0;
            irq_line_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
            irq_line_reg <= |(irq_status_next & irq_mask_reg);
        end
    end

    assign control_irq_out = irq_reg.sci;
    assign mgmt_irq_n_out = ~irq_reg.smi;
    assign irq13_out = irq_reg.irq13;
    assign irq_out = irq_line_reg;

endmodule // per_pm_event_router
